// ---- link_host_control.sv ----
// link host control register with set/clear addresses, behind an APB slave
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "link_ctrl_regs.svh"

module link_host_control (
    input  wire  logic                        pclk,
    input  wire  logic                        presetn,
    input  wire  logic                        psel,
    input  wire  logic                        penable,
    input  wire  logic                        pwrite,
    input  wire  logic [11:0]                 paddr,
    input  wire  logic [31:0]                 pwdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic [31:0]                       prdata,
    input  wire  logic                        abort_suppress,
    input  wire  logic                        phy_clock_running,
    input  wire  logic                        eeprom_load,
    input  wire  logic                        eeprom_permit,
    input  wire  logic                        phy_tx_request,
    output logic                              phy_grant,
    output logic                              rx_enable,
    output logic                              tx_enable,
    output link_ctrl_pkg::link_status_t       status
);
    import link_ctrl_pkg::*;

    state_t  s_reg;
    state_t  s_next;
    decode_t dec;
    logic    access_first;
    logic    access_done;
    logic    in_phy_range;
    logic    wr_set;
    logic    wr_clr;
    logic [31:0] rd_val;

    // R7: PHY clock domain address ranges
    assign in_phy_range = ((paddr >= `ADDR_PHY_A_LO) && (paddr <= `ADDR_PHY_A_HI))
                       || ((paddr >= `ADDR_PHY_B_LO) && (paddr <= `ADDR_PHY_B_HI));

    assign access_first = psel && penable && !s_reg.pready;
    assign access_done  = psel && penable && s_reg.pready;
    assign wr_set = access_done && pwrite && !s_reg.pslverr && (paddr == `ADDR_CTRL_SET);
    assign wr_clr = access_done && pwrite && !s_reg.pslverr && (paddr == `ADDR_CTRL_CLR);

    always_comb begin
        if ((paddr == `ADDR_CTRL_SET) || (paddr == `ADDR_CTRL_CLR)) begin
            dec = DEC_CTRL;
        end else if (in_phy_range) begin
            dec = DEC_PHY;
        end else begin
            dec = DEC_NONE;
        end
    end

    // R21: both addresses show the same contents
    always_comb begin
        rd_val = `READ_ZERO;
        rd_val[`BIT_PERMIT]  = s_reg.phy_program_permit;
        rd_val[`BIT_ENHANCE] = s_reg.phy_enhancement_enable;
        rd_val[`BIT_LPS]     = s_reg.link_power_status;
        rd_val[`BIT_BUF_WR]  = s_reg.buffered_write_enable;
        rd_val[`BIT_LINK_EN] = s_reg.link_active_enable;
        rd_val[`BIT_SRST]    = s_reg.software_reset_trigger;
    end

    always_comb begin
        s_next = s_reg;
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;

        // answer one cycle into the access phase so outputs stay registered
        if (access_first) begin
            s_next.pready = 1'b1;
            s_next.prdata = `READ_ZERO;
            case (dec)
                DEC_CTRL: begin
                    // R3: unused bits come from a zero base
                    // R17: low half reads zero
                    s_next.prdata = rd_val;
                end
                DEC_PHY: begin
                    if (!phy_clock_running) begin
                        // R15: config-space bit outlives soft reset
                        // R6: suppressed abort reads all ones
                        if (abort_suppress) begin
                            s_next.prdata = `READ_ALL_ONES;
                        end else begin
                            // R5: target abort on stopped clock
                            s_next.pslverr = 1'b1;
                        end
                    end
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
        end

        // R19: set and clear addresses
        if (!s_reg.software_reset_trigger && (wr_set || wr_clr)) begin
            // R21: zero bits leave fields alone
            if (pwdata[`BIT_LPS]) begin
                s_next.link_power_status = wr_set;
            end
            // R10: buffered write frozen while link enabled
            if (pwdata[`BIT_BUF_WR] && !s_reg.link_active_enable) begin
                s_next.buffered_write_enable = wr_set;
            end
            if (pwdata[`BIT_LINK_EN]) begin
                s_next.link_active_enable = wr_set;
            end
            // R1: enhancement set needs permit and link enable
            if (pwdata[`BIT_ENHANCE] && wr_set && s_reg.phy_program_permit
                    && s_reg.link_active_enable) begin
                s_next.phy_enhancement_enable = 1'b1;
            end
            // R2: clear also blocked without permit
            if (pwdata[`BIT_ENHANCE] && wr_clr && s_reg.phy_program_permit) begin
                s_next.phy_enhancement_enable = 1'b0;
            end
            // R14: software reset start, set address only
            if (pwdata[`BIT_SRST] && wr_set) begin
                s_next.software_reset_trigger = 1'b1;
                s_next.srst_cnt               = `SRST_CYCLES;
            end
        end

        // R16: bit stays 1 while counting, then self-clears
        if (s_reg.software_reset_trigger) begin
            if (s_reg.srst_cnt == `SRST_LAST) begin
                s_next.software_reset_trigger = 1'b0;
                s_next.srst_cnt               = `SRST_IDLE;
            end else begin
                s_next.srst_cnt = s_reg.srst_cnt - `SRST_LAST;
            end
        end

        // R11: link enable cleared by software reset
        // R14: all link controls back to defaults
        if (s_next.software_reset_trigger) begin
            s_next.link_active_enable     = `RST_CTRL_BIT;
            s_next.buffered_write_enable  = `RST_CTRL_BIT;
            s_next.link_power_status      = `RST_CTRL_BIT;
            s_next.phy_enhancement_enable = `RST_CTRL_BIT;
        end

        // R20: permit loaded from EEPROM
        // R18: software reset never touches permit
        if (eeprom_load) begin
            s_next.phy_program_permit = eeprom_permit;
        end

        // R13: disconnected the cycle link enable drops
        s_next.rx_enable = s_next.link_active_enable && !s_next.software_reset_trigger;
        s_next.tx_enable = s_next.link_active_enable && !s_next.software_reset_trigger;
        // R4: power status gates PHY traffic
        s_next.phy_grant = s_next.link_power_status && phy_tx_request;
        // R9: posted writes follow the bit
        s_next.status.buffered_write_enable  = s_next.buffered_write_enable;
        s_next.status.link_active_enable     = s_next.link_active_enable;
        s_next.status.link_power_status      = s_next.link_power_status;
        s_next.status.phy_enhancement_enable = s_next.phy_enhancement_enable;
        s_next.status.fifo_flush             = s_next.software_reset_trigger;
    end

    // R11: hardware reset clears link enable
    // R18: the global reset loads permit with its default of 1; software reset leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg                        <= '0;
            s_reg.phy_program_permit     <= `RST_PERMIT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready    = s_reg.pready;
    assign pslverr   = s_reg.pslverr;
    assign prdata    = s_reg.prdata;
    assign phy_grant = s_reg.phy_grant;
    assign rx_enable = s_reg.rx_enable;
    assign tx_enable = s_reg.tx_enable;
    assign status    = s_reg.status;

    AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R3 R17
        access_first && dec == DEC_CTRL
        |=> prdata[`BIT_RSVD_HI:`BIT_RSVD_LO] == 2'h0 && prdata[`BIT_LOW_HI:`BIT_LOW_LO] == 16'h0)
        else $error("reserved bits read nonzero");

    AST_LPS_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R4
        !status.link_power_status |-> !phy_grant)
        else $error("phy grant while link power status is 0");

    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn) // R5
        access_first && dec == DEC_PHY && !phy_clock_running && !abort_suppress
        |=> pready && pslverr)
        else $error("no abort on stopped phy clock");

    AST_ALL_ONES: assert property (@(posedge pclk) disable iff (!presetn) // R6
        access_first && dec == DEC_PHY && !phy_clock_running && abort_suppress
        |=> pready && !pslverr && prdata == `READ_ALL_ONES)
        else $error("suppressed access did not read all ones");

    AST_BUF_WR: assert property (@(posedge pclk) disable iff (!presetn) // R9
        wr_set && pwdata[`BIT_BUF_WR] && !pwdata[`BIT_SRST] && !status.link_active_enable
            && !s_reg.software_reset_trigger
        |=> status.buffered_write_enable)
        else $error("buffered write enable not set");

    AST_SRST_LINK: assert property (@(posedge pclk) disable iff (!presetn) // R11
        s_reg.software_reset_trigger |-> !status.link_active_enable)
        else $error("link enabled during software reset");

    AST_DISCONNECT: assert property (@(posedge pclk) disable iff (!presetn) // R13
        !status.link_active_enable |-> !rx_enable && !tx_enable)
        else $error("link active while disabled");

    AST_SRST_DONE: assert property (@(posedge pclk) disable iff (!presetn) // R16
        $rose(s_reg.software_reset_trigger) |-> s_reg.software_reset_trigger[*8]
        ##1 !s_reg.software_reset_trigger)
        else $error("software reset length wrong");

    AST_PERMIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R18
        !$past(eeprom_load) |-> $stable(s_reg.phy_program_permit))
        else $error("permit changed without eeprom load");

    AST_SET_CLR: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (wr_set || wr_clr) && pwdata[`BIT_LPS] && !(wr_set && pwdata[`BIT_SRST])
            && !s_reg.software_reset_trigger
        |=> status.link_power_status == $past(wr_set))
        else $error("set/clear did not reach link power status");

    AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // R19
        pready
        |=> !pready)
        else $error("pready held longer than one cycle");

    AST_ANSWER_TIME: assert property (@(posedge pclk) disable iff (!presetn) // R21
        psel && penable && !pready
        |=> pready)
        else $error("no answer in second access cycle");

    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn) // R5
        pslverr
        |-> pready)
        else $error("error response without pready");

    AST_PRDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R21
        !pready
        |-> $stable(prdata))
        else $error("read data changed between answers");

    AST_CTRL_OKAY: assert property (@(posedge pclk) disable iff (!presetn) // R21
        access_first && dec == DEC_CTRL
        |=> pready && !pslverr && prdata == $past(rd_val))
        else $error("control read did not return contents");

    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn) // R7
        access_first && dec == DEC_NONE
        |=> pready && pslverr && prdata == `READ_ZERO)
        else $error("unmapped access not refused");

    AST_PHY_RUNNING: assert property (@(posedge pclk) disable iff (!presetn) // R7
        access_first && dec == DEC_PHY && phy_clock_running
        |=> pready && !pslverr)
        else $error("phy range access refused with clock running");

    AST_GRANT_REQ: assert property (@(posedge pclk) disable iff (!presetn) // R4
        !$past(phy_tx_request)
        |-> !phy_grant)
        else $error("phy grant without request");

    AST_GRANT_ON: assert property (@(posedge pclk) disable iff (!presetn) // R4
        status.link_power_status && $past(phy_tx_request)
        |-> phy_grant)
        else $error("phy grant missing while powered");

    AST_LPS_CLR: assert property (@(posedge pclk) disable iff (!presetn) // R19
        wr_clr && pwdata[`BIT_LPS]
        |=> !status.link_power_status)
        else $error("link power status not cleared");

    AST_LINK_EN_SET: assert property (@(posedge pclk) disable iff (!presetn) // R19
        wr_set && pwdata[`BIT_LINK_EN] && !pwdata[`BIT_SRST] && !s_reg.software_reset_trigger
        |=> status.link_active_enable)
        else $error("link enable not set");

    AST_LINK_EN_CLR: assert property (@(posedge pclk) disable iff (!presetn) // R13
        wr_clr && pwdata[`BIT_LINK_EN]
        |=> !status.link_active_enable && !rx_enable && !tx_enable)
        else $error("link not disconnected on clear");

    AST_RX_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn) // R13
        rx_enable == (status.link_active_enable && !status.fifo_flush))
        else $error("receive enable does not follow link enable");

    AST_TX_RX_SAME: assert property (@(posedge pclk) disable iff (!presetn) // R13
        tx_enable == rx_enable)
        else $error("transmit and receive enables differ");

    AST_ENH_SET: assert property (@(posedge pclk) disable iff (!presetn) // R1
        wr_set && pwdata[`BIT_ENHANCE] && !pwdata[`BIT_SRST] && !s_reg.software_reset_trigger
            && s_reg.phy_program_permit && s_reg.link_active_enable
        |=> status.phy_enhancement_enable)
        else $error("enhancement enable not set");

    AST_ENH_NEEDS: assert property (@(posedge pclk) disable iff (!presetn) // R1
        $rose(status.phy_enhancement_enable)
        |-> $past(s_reg.phy_program_permit) && $past(s_reg.link_active_enable))
        else $error("enhancement enabled without permit and link");

    AST_ENH_FROZEN: assert property (@(posedge pclk) disable iff (!presetn) // R2
        !s_reg.phy_program_permit && !s_next.software_reset_trigger
        |=> $stable(s_reg.phy_enhancement_enable))
        else $error("enhancement changed without permit");

    AST_BUF_FROZEN: assert property (@(posedge pclk) disable iff (!presetn) // R10
        s_reg.link_active_enable && !s_next.software_reset_trigger
        |=> $stable(s_reg.buffered_write_enable))
        else $error("buffered write changed while link enabled");

    AST_SRST_START: assert property (@(posedge pclk) disable iff (!presetn) // R14
        wr_set && pwdata[`BIT_SRST] && !s_reg.software_reset_trigger
        |=> s_reg.software_reset_trigger && s_reg.srst_cnt == `SRST_CYCLES)
        else $error("software reset did not start");

    AST_SRST_ONLY_SET: assert property (@(posedge pclk) disable iff (!presetn) // R19
        wr_clr && pwdata[`BIT_SRST] && !s_reg.software_reset_trigger
        |=> !s_reg.software_reset_trigger)
        else $error("software reset started from clear address");

    AST_SRST_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // R14
        s_reg.software_reset_trigger
        |-> !status.phy_enhancement_enable && !status.buffered_write_enable
            && !status.link_power_status && status.fifo_flush)
        else $error("controls not at defaults during software reset");

    AST_PERMIT_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // R20
        eeprom_load
        |=> s_reg.phy_program_permit == $past(eeprom_permit))
        else $error("permit not loaded from eeprom");

    AST_SRST_CNT_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // R16
        s_reg.software_reset_trigger == (s_reg.srst_cnt != `SRST_IDLE))
        else $error("software reset flag and counter disagree");

endmodule

// ---- link_ctrl_regs.svh ----
// address map, field positions and reset values of the link host control register
// Functional notes
// R1: software enables PHY enhancements only while program permit and link enable are 1.
// R2: with program permit 0, software leaves enhancements and their enable alone.
// R3: bits 21 and 20 read as zero.
// R4: link power status 1 permits link-PHY traffic, 0 blocks it completely.
// R5: PHY-clock register access while that clock is stopped gets a target abort.
// R6: with abort suppress set, such accesses complete and read all ones.
// R7: offsets DCh-F0h and 100h-11Ch live in the PHY clock domain.
// R8: software waits about 10 ms after setting link power status.
// R9: buffered write enable turns posted writes on (1) or off (0).
// R10: software changes buffered write enable only while link enable is 0.
// R11: link enable clears on hardware reset and on software reset.
// R12: software sets link enable when ready, then forces a bus reset.
// R13: link enable 0 disconnects the link at once: no receive, no transmit.
// R14: software reset clears internal state, flushes FIFOs, restores register defaults.
// R15: software reset leaves configuration-space registers untouched.
// R16: software reset bit reads 1 while busy, then clears itself.
// R17: bits 15 to 0 read as zero.
// R18: program permit clears only on global reset, never on software reset.
// R19: set address sets bits written as one, clear address clears them.
// R20: program permit loads from serial EEPROM and defaults to 1.
// R21: both addresses read current contents; zero bits in a write change nothing.
`ifndef LINK_CTRL_REGS_SVH
`define LINK_CTRL_REGS_SVH

`define ADDR_CTRL_SET    12'h050
`define ADDR_CTRL_CLR    12'h054
`define ADDR_PHY_A_LO    12'h0dc
`define ADDR_PHY_A_HI    12'h0f0
`define ADDR_PHY_B_LO    12'h100
`define ADDR_PHY_B_HI    12'h11c

`define BIT_PERMIT       23
`define BIT_ENHANCE      22
`define BIT_LPS          19
`define BIT_BUF_WR       18
`define BIT_LINK_EN      17
`define BIT_SRST         16
`define BIT_RSVD_HI      21
`define BIT_RSVD_LO      20
`define BIT_LOW_HI       15
`define BIT_LOW_LO       0

`define RST_PERMIT       1'b1
`define RST_CTRL_BIT     1'b0
`define SRST_CYCLES      4'h8
`define SRST_LAST        4'h1
`define SRST_IDLE        4'h0
`define READ_ZERO        32'h0000_0000
`define READ_ALL_ONES    32'hffff_ffff

`endif

// ---- link_ctrl_pkg.sv ----
// types shared by the link host control register block
package link_ctrl_pkg;

    typedef enum logic [1:0] {
        DEC_NONE = 2'b00,
        DEC_CTRL = 2'b01,
        DEC_PHY  = 2'b10
    } decode_t;

    typedef struct packed {
        logic link_active_enable;
        logic buffered_write_enable;
        logic link_power_status;
        logic phy_enhancement_enable;
        logic fifo_flush;
    } link_status_t;

    typedef struct packed {
        logic        phy_program_permit;
        logic        phy_enhancement_enable;
        logic        link_power_status;
        logic        buffered_write_enable;
        logic        link_active_enable;
        logic        software_reset_trigger;
        logic [3:0]  srst_cnt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        rx_enable;
        logic        tx_enable;
        logic        phy_grant;
        link_status_t status;
    } state_t;

endpackage

// ---- link_host_control_test.sv ----
// self-checking bench for the link host control register block
`timescale 1ns/1ns
`include "link_ctrl_regs.svh"

module link_host_control_test;
    import link_ctrl_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rdat;
    logic         abort_suppress, phy_clock_running, eeprom_load, eeprom_permit;
    logic         phy_tx_request, phy_grant, rx_enable, tx_enable, rerr;
    link_status_t status;
    logic [11:0]  phy_addr [4] = '{12'h0dc, 12'h0f0, 12'h100, 12'h11c};
    int           fail_count, n_compared;

    link_host_control u_link_host_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .abort_suppress(abort_suppress),
        .phy_clock_running(phy_clock_running), .eeprom_load(eeprom_load),
        .eeprom_permit(eeprom_permit), .phy_tx_request(phy_tx_request),
        .phy_grant(phy_grant), .rx_enable(rx_enable), .tx_enable(tx_enable),
        .status(status)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task final_report;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t data got %h expected %h", $time, got, exp);
        end
    endtask

    task chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; request held until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk1(rerr, 1'b0);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0000_0000);
        chk32(rdat, exp);
        chk1(rerr, eexp);
    endtask

    // registered outputs lag the write by a cycle or two
    task settle;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        #50000;
        fail_count++;
        final_report;
    end

    initial begin
        {presetn, psel, penable, pwrite, eeprom_load, eeprom_permit} = 6'h00;
        {abort_suppress, phy_clock_running, phy_tx_request} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        n_compared = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`ADDR_CTRL_SET, 32'h0080_0000, 1'b0);
        rd(`ADDR_CTRL_CLR, 32'h0080_0000, 1'b0);
        phy_tx_request <= 1'b1;
        // settle wait shortened, phy clock state is a bench-driven level
        wr(`ADDR_CTRL_SET, 32'h0038_ffff);
        rd(`ADDR_CTRL_CLR, 32'h0088_0000, 1'b0);
        settle;
        chk1(phy_grant, 1'b1);
        chk1(status.link_power_status, 1'b1);
        wr(`ADDR_CTRL_CLR, 32'h0008_0000);
        settle;
        chk1(phy_grant, 1'b0);
        chk1(rx_enable, 1'b0);
        wr(`ADDR_CTRL_SET, 32'h0004_0000);
        wr(`ADDR_CTRL_SET, 32'h0002_0000);
        // buffered write clear refused while the link is enabled
        wr(`ADDR_CTRL_CLR, 32'h0004_0000);
        wr(`ADDR_CTRL_SET, 32'h0040_0000);
        rd(`ADDR_CTRL_SET, 32'h00c6_0000, 1'b0);
        settle;
        chk1(status.buffered_write_enable, 1'b1);
        chk1(status.phy_enhancement_enable, 1'b1);
        chk1(rx_enable, 1'b1);
        chk1(tx_enable, 1'b1);
        wr(`ADDR_CTRL_SET, 32'h0001_0000);
        rd(`ADDR_CTRL_SET, 32'h0081_0000, 1'b0);
        chk1(status.fifo_flush, 1'b1);
        chk1(rx_enable, 1'b0);
        repeat (10) @(posedge pclk);
        rd(`ADDR_CTRL_SET, 32'h0080_0000, 1'b0);
        chk1(status.link_active_enable, 1'b0);
        chk1(status.fifo_flush, 1'b0);
        wr(`ADDR_CTRL_CLR, 32'h0001_0000);
        rd(`ADDR_CTRL_SET, 32'h0080_0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            phy_clock_running <= 1'b0;
            abort_suppress <= 1'b0;
            rd(phy_addr[i], 32'h0000_0000, 1'b1);
            abort_suppress <= 1'b1;
            rd(phy_addr[i], 32'hffff_ffff, 1'b0);
            phy_clock_running <= 1'b1;
            rd(phy_addr[i], 32'h0000_0000, 1'b0);
        end
        // addresses just outside the PHY ranges are unmapped
        rd(12'h0d8, 32'h0000_0000, 1'b1);
        rd(12'h120, 32'h0000_0000, 1'b1);
        eeprom_permit <= 1'b0;
        eeprom_load <= 1'b1;
        @(posedge pclk);
        eeprom_load <= 1'b0;
        wr(`ADDR_CTRL_SET, 32'h0002_0000);
        wr(`ADDR_CTRL_SET, 32'h0040_0000);
        rd(`ADDR_CTRL_SET, 32'h0002_0000, 1'b0);
        wr(`ADDR_CTRL_SET, 32'h0001_0000);
        repeat (12) @(posedge pclk);
        // permit stays cleared across a software reset
        rd(`ADDR_CTRL_SET, 32'h0000_0000, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`ADDR_CTRL_CLR, 32'h0080_0000, 1'b0);
        final_report;
    end
endmodule
